/* design/pdw_regs.vh */
// Constants for the power-down and pin wakeup block.
// Function
// - Power-down entered only by executing the low-power instruction.
// - While powered down only the watchdog, the pin edge detectors with their pending flags and the external reset synchroniser run; everything else halts.
// - Sleep with watchdog enabled clears count, sets expired flag, clears powered-down flag.
// - Power-down ends on watchdog overflow, enabled pin edge, or external reset.
// - Pin wakeup loads program counter with top address, like reset.
// - Enable mask bit low enables wakeup on its pin.
// - Edge select bit set means falling edge, clear means rising.
// - Reset sets enable mask and edge select to all ones.
// - Selected edge latches a one into pending flag until software clears.
// - Pending flags are not initialised by reset.
// - Select index 09 makes port write swap accumulator with pending flags.
// - Select index 0A writes edge select, 0B writes enable mask.
// - Enabled pending flags raise interrupts while running and wake when asleep.
`ifndef PDW_REGS_VH
`define PDW_REGS_VH
`define PDW_SEL_PENDING   4'h9
`define PDW_SEL_EDGE      4'hA
`define PDW_SEL_MASK      4'hB
`define PDW_MASK_RESET    8'hFF
`define PDW_EDGE_RESET    8'hFF
`define PDW_RESET_VECTOR  11'h7FF
`define PDW_WATCHDOG_WIDTH 16
`endif

/* design/pdw_edge_detect.v */
// Pin synchroniser and per-pin selected-edge detector.
`timescale 1ns/1ps
module pdw_edge_detect
#(
  parameter WIDTH = 8
)
(
  input  wire             core_clk_in,
  input  wire             rst_n_in,
  input  wire [WIDTH-1:0] pin_in,
  input  wire [WIDTH-1:0] falling_sel_in,
  output wire [WIDTH-1:0] edge_out
);

  reg [WIDTH-1:0] sync1_reg;
  reg [WIDTH-1:0] sync2_reg;
  reg [WIDTH-1:0] sync3_reg;
  reg [WIDTH-1:0] stable_reg;
  reg [WIDTH-1:0] prev_reg;
  reg             primed_reg;

  // -------------------------------------------------------------
  // Three-stage synchroniser; a level counts once stages two and three agree.
  // -------------------------------------------------------------
  integer i;
  always @(posedge core_clk_in)
  begin
    sync1_reg <= pin_in;
    sync2_reg <= sync1_reg;
    sync3_reg <= sync2_reg;
    for (i = 0; i < WIDTH; i = i + 1)
    begin
      if (sync2_reg[i] == sync3_reg[i])
      begin
        stable_reg[i] <= sync3_reg[i];
      end
    end
    prev_reg <= stable_reg;
    if (!rst_n_in)
    begin
      primed_reg <= 1'b0;
    end
    else
    begin
      primed_reg <= 1'b1;
    end
  end

  // Falling when the select bit is set, rising otherwise.
  assign edge_out = primed_reg ? ((falling_sel_in & prev_reg & ~stable_reg) |
                                  (~falling_sel_in & ~prev_reg & stable_reg)) : {WIDTH{1'b0}};

endmodule

/* design/pdw_power_wakeup.v */
// Power-down control and port B pin wakeup logic.
`timescale 1ns/1ps
`include "pdw_regs.vh"
module pdw_power_wakeup
#(
  parameter PINS      = 8,
  parameter WATCHDOG_LIMIT = 16'hFFFF
)
(
  input  wire              core_clk_in,
  input  wire              rst_n_in,
  input  wire              external_reset_pin_n_in,
  input  wire              watchdog_enable_in,
  input  wire              sleep_exec_in,
  input  wire              clear_watchdog_exec_in,
  input  wire              port_b_write_in,
  input  wire [3:0]        port_select_in,
  input  wire [PINS-1:0]   accumulator_in,
  input  wire [PINS-1:0]   port_b_pins_in,
  output reg               powered_down_out,
  output reg               core_run_out,
  output reg               watchdog_expired_flag_out,
  output reg               powered_down_flag_out,
  output reg               pc_load_out,
  output reg  [10:0]       pc_value_out,
  output reg               interrupt_request_out,
  output reg               accumulator_load_out,
  output reg  [PINS-1:0]   accumulator_value_out,
  output reg  [PINS-1:0]   wakeup_enable_mask_out,
  output reg  [PINS-1:0]   wakeup_edge_select_out,
  output reg  [PINS-1:0]   wakeup_pending_flags_out
);

  reg  [`PDW_WATCHDOG_WIDTH-1:0] watchdog_timer_reg;
  reg  [`PDW_WATCHDOG_WIDTH-1:0] watchdog_timer_next;
  reg  [2:0]                     ext_reset_sync_reg;
  reg                            ext_reset_stable_reg;
  reg  [PINS-1:0]                pending_next;
  wire [PINS-1:0]                edge_hit;
  wire                           watchdog_overflow;
  wire                           pin_wake;
  wire                           swap_write;
  wire                           ext_reset_active;
  wire                           wake_request;

  // -------------------------------------------------------------
  // Port select decode, used only by the swap path; the register writes decode in their own case.
  // -------------------------------------------------------------
  function sel_match;
    input [3:0] sel;
    input [3:0] code;
    begin
      sel_match = (sel == code);
    end
  endfunction

  // -------------------------------------------------------------
  // Edge detection, kept running in power-down.
  // -------------------------------------------------------------
  pdw_edge_detect
  #(
    .WIDTH (PINS)
  )
  u_edge
  (
    .core_clk_in    (core_clk_in),
    .rst_n_in       (rst_n_in),
    .pin_in         (port_b_pins_in),
    .falling_sel_in (wakeup_edge_select_out),
    .edge_out       (edge_hit)
  );

  // -------------------------------------------------------------
  // External reset pin synchroniser.
  // -------------------------------------------------------------
  // The pin is asynchronous, so a level only counts once stages two and three agree.
  always @(posedge core_clk_in)
  begin
    ext_reset_sync_reg <= {ext_reset_sync_reg[1:0], external_reset_pin_n_in};
    if (ext_reset_sync_reg[1] == ext_reset_sync_reg[2])
    begin
      ext_reset_stable_reg <= ext_reset_sync_reg[2];
    end
  end

  assign watchdog_overflow = watchdog_enable_in && (watchdog_timer_reg == WATCHDOG_LIMIT);
  assign pin_wake          = |(wakeup_pending_flags_out & ~wakeup_enable_mask_out);
  assign swap_write        = port_b_write_in && core_run_out && sel_match(port_select_in, `PDW_SEL_PENDING);

  // -------------------------------------------------------------
  // Wake sources while powered down.
  // -------------------------------------------------------------
  // The external pin is kept apart because it also holds the program counter load.
  assign ext_reset_active = !ext_reset_stable_reg;
  assign wake_request     = watchdog_overflow || pin_wake;

  // -------------------------------------------------------------
  // Watchdog count.
  // -------------------------------------------------------------
  // The count restarts on sleep so a full period always separates sleep from a watchdog wake.
  always @*
  begin
    watchdog_timer_next = watchdog_timer_reg + 1'b1;
    if (!watchdog_enable_in || watchdog_overflow || clear_watchdog_exec_in ||
        (sleep_exec_in && core_run_out))
    begin
      watchdog_timer_next = {`PDW_WATCHDOG_WIDTH{1'b0}};
    end
  end

  // -------------------------------------------------------------
  // Pending flags: an edge wins over a swap clear in the same cycle.
  // -------------------------------------------------------------
  always @*
  begin
    pending_next = wakeup_pending_flags_out;
    if (swap_write)
    begin
      pending_next = accumulator_in;
    end
    pending_next = pending_next | edge_hit;
  end

  // Pending flags have no reset and power up undefined.
  always @(posedge core_clk_in)
  begin
    wakeup_pending_flags_out <= pending_next;
  end

  // -------------------------------------------------------------
  // Power state, status flags, configuration registers.
  // -------------------------------------------------------------
  always @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      watchdog_timer_reg        <= {`PDW_WATCHDOG_WIDTH{1'b0}};
      powered_down_out          <= 1'b0;
      core_run_out              <= 1'b1;
      watchdog_expired_flag_out <= 1'b1;
      powered_down_flag_out     <= 1'b1;
      pc_load_out               <= 1'b1;
      pc_value_out              <= `PDW_RESET_VECTOR;
      interrupt_request_out     <= 1'b0;
      accumulator_load_out      <= 1'b0;
      accumulator_value_out     <= {PINS{1'b0}};
      wakeup_enable_mask_out    <= `PDW_MASK_RESET;
      wakeup_edge_select_out    <= `PDW_EDGE_RESET;
    end
    else
    begin
      watchdog_timer_reg    <= watchdog_timer_next;
      pc_load_out           <= 1'b0;
      pc_value_out          <= `PDW_RESET_VECTOR;
      accumulator_load_out  <= 1'b0;
      interrupt_request_out <= core_run_out && pin_wake;
      if (ext_reset_active)
      begin
        powered_down_out <= 1'b0;
        core_run_out     <= 1'b1;
        pc_load_out      <= 1'b1;
      end
      else if (powered_down_out)
      begin
        if (wake_request)
        begin
          powered_down_out <= 1'b0;
          core_run_out     <= 1'b1;
          pc_load_out      <= 1'b1;
          if (watchdog_overflow)
          begin
            watchdog_expired_flag_out <= 1'b0;
          end
        end
      end
      else
      begin
        if (watchdog_overflow)
        begin
          watchdog_expired_flag_out <= 1'b0;
        end
        if (clear_watchdog_exec_in)
        begin
          watchdog_expired_flag_out <= 1'b1;
          powered_down_flag_out     <= 1'b1;
        end
        if (sleep_exec_in)
        begin
          powered_down_out          <= 1'b1;
          core_run_out              <= 1'b0;
          watchdog_expired_flag_out <= 1'b1;
          powered_down_flag_out     <= 1'b0;
        end
        if (port_b_write_in)
        begin
          case (port_select_in)
            `PDW_SEL_PENDING:
            begin
              accumulator_load_out  <= 1'b1;
              accumulator_value_out <= wakeup_pending_flags_out;
            end
            `PDW_SEL_EDGE:
            begin
              wakeup_edge_select_out <= accumulator_in;
            end
            `PDW_SEL_MASK:
            begin
              wakeup_enable_mask_out <= accumulator_in;
            end
            default:
            begin
              accumulator_load_out <= 1'b0;
            end
          endcase
        end
      end
    end
  end

endmodule

/* tb/pdw_power_wakeup_monitor.sv */
// Assertion checker for the power-down and pin wakeup block.
`timescale 1ns/1ps
module pdw_power_wakeup_monitor #(parameter PINS = 8) (
  input logic            core_clk_in, rst_n_in, external_reset_pin_n_in, watchdog_enable_in,
  input logic            sleep_exec_in, port_b_write_in, powered_down_out, core_run_out,
  input logic            watchdog_expired_flag_out, powered_down_flag_out, pc_load_out,
  input logic            interrupt_request_out, accumulator_load_out,
  input logic [3:0]      port_select_in,
  input logic [10:0]     pc_value_out,
  input logic [PINS-1:0] accumulator_in, wakeup_enable_mask_out, wakeup_edge_select_out,
  input logic [PINS-1:0] wakeup_pending_flags_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire wr_ok = port_b_write_in && core_run_out;
  wire go_sleep = sleep_exec_in && core_run_out && external_reset_pin_n_in;
  AST_RUN_INV: assert property (core_run_out == !powered_down_out)
    else $error("run and power-down disagree");
  AST_SLEEP_ENTRY: assert property (go_sleep |=> powered_down_out)
    else $error("sleep not entered");
  AST_ONLY_SLEEP: assert property ($rose(powered_down_out) |-> $past(sleep_exec_in))
    else $error("power-down without sleep");
  AST_SLEEP_FLAGS: assert property (go_sleep && watchdog_enable_in |=> watchdog_expired_flag_out && !powered_down_flag_out)
    else $error("status flags wrong after sleep");
  AST_WAKE_PIN: assert property (powered_down_out && |(wakeup_pending_flags_out & ~wakeup_enable_mask_out) |=> !powered_down_out)
    else $error("no wake on enabled pending pin");
  AST_WAKE_PC: assert property ($fell(powered_down_out) |-> pc_load_out && pc_value_out == 11'h7FF)
    else $error("wake without reset vector load");
  AST_EDGE_WR: assert property (wr_ok && port_select_in == 4'hA |=> wakeup_edge_select_out == $past(accumulator_in))
    else $error("edge select write lost");
  AST_MASK_WR: assert property (wr_ok && port_select_in == 4'hB |=> wakeup_enable_mask_out == $past(accumulator_in))
    else $error("enable mask write lost");
  AST_SWAP_PULSE: assert property (wr_ok && port_select_in == 4'h9 |=> accumulator_load_out ##1 (!accumulator_load_out || $past(wr_ok && port_select_in == 4'h9)))
    else $error("swap load pulse wrong");
  AST_IRQ_ASLEEP: assert property (powered_down_out && $past(powered_down_out) |-> !interrupt_request_out)
    else $error("interrupt while powered down");
  cover property ($fell(powered_down_out));
  cover property (accumulator_load_out);
  cover property (interrupt_request_out);
endmodule
bind pdw_power_wakeup pdw_power_wakeup_monitor #(.PINS(PINS)) u_mon (.*);

/* tb/pdw_pin_model.sv */
// Port B pin source model.
`timescale 1ns/1ps
module pdw_pin_model (
  input  logic       core_clk_in,
  input  logic [7:0] level_in,
  output logic [7:0] pins_out
);
  initial pins_out = 8'h00;
  // Pins move away from the sampling edge, as a slow outside source would.
  always @(negedge core_clk_in) pins_out <= level_in;
endmodule

/* tb/tb_top.sv */
// Self-checking testbench for the power-down and pin wakeup block.
`timescale 1ns/1ps
module tb_top;
  logic        clk = 0, rst_n = 0, slp = 0, wr_en = 0, ext_n = 1, pd, run, tof, pdf, pcl, irq, accl;
  logic [3:0]  sel = 4'h0;
  logic [10:0] pcv;
  logic [7:0]  acc = 8'h00, lvl = 8'h00, pins, msk, edg, pend, old, v, accv, mask_o, edge_o, pend_o;
  integer      seed = 32'h0cae, num_errors = 0, tests_run = 0, i, n;
  always #10 clk = ~clk;
  pdw_pin_model u_pins (.core_clk_in(clk), .level_in(lvl), .pins_out(pins));
  pdw_power_wakeup #(.WATCHDOG_LIMIT(16'h0010)) dut (.core_clk_in(clk), .rst_n_in(rst_n),
    .external_reset_pin_n_in(ext_n), .watchdog_enable_in(1'b1), .sleep_exec_in(slp),
    .clear_watchdog_exec_in(1'b0), .port_b_write_in(wr_en), .port_select_in(sel), .accumulator_in(acc),
    .port_b_pins_in(pins), .powered_down_out(pd), .core_run_out(run), .watchdog_expired_flag_out(tof),
    .powered_down_flag_out(pdf), .pc_load_out(pcl), .pc_value_out(pcv), .interrupt_request_out(irq),
    .accumulator_load_out(accl), .accumulator_value_out(accv), .wakeup_enable_mask_out(mask_o),
    .wakeup_edge_select_out(edge_o), .wakeup_pending_flags_out(pend_o));
  function logic [7:0] sel_edges(input logic [7:0] a, b, e);
    sel_edges = (e & a & ~b) | (~e & ~a & b);
  endfunction
  task end_of_test;
    if (num_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [11:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] s, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1;
    sel = s;
    acc = d;
    @(negedge clk);
    wr_en = 0;
  endtask
  task pulse_sleep;
    @(negedge clk);
    slp = 1;
    @(negedge clk);
    slp = 0;
  endtask
  task wait_wake;
    n = 0;
    while (pd !== 1'b0 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    if (pd !== 1'b0)
    begin
      num_errors++;
      end_of_test;
    end
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    chk(12'(mask_o), 12'hFF);
    chk(12'(edge_o), 12'hFF);
    rst_n = 1;
    edg = $random(seed);
    msk = $random(seed);
    wr(4'hA, edg);
    wr(4'h9, 8'h00);
    wr(4'hB, msk);
    chk(12'(edge_o), 12'(edg));
    chk(12'(mask_o), 12'(msk));
    pend = 8'h00;
    for (i = 0; i < 24; i++)
    begin
      old = lvl;
      lvl = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : $random(seed);
      repeat (8) @(negedge clk);
      pend = pend | sel_edges(old, lvl, edg);
      chk(12'(pend_o), 12'(pend));
      chk(12'(irq), 12'(|(pend & ~msk)));
      if (i % 3 == 2)
      begin
        v = (i % 2) ? $random(seed) : 8'h00;
        wr(4'h9, v);
        chk(12'(accl), 12'h1);
        @(negedge clk);
        chk(12'(accv), 12'(pend));
        pend = v;
      end
    end
    wr(4'hB, 8'hFE);
    lvl = {lvl[7:1], edg[0]};
    repeat (8) @(negedge clk);
    wr(4'h9, 8'h00);
    pulse_sleep;
    chk({pd, run, tof, pdf}, 12'hA);
    wr(4'hB, 8'h00);
    lvl[0] = ~edg[0];
    wait_wake;
    chk({pcl, pcv}, 12'hFFF);
    chk(12'(mask_o), 12'hFE);
    wr(4'hB, 8'hFF);
    pulse_sleep;
    wait_wake;
    chk(12'(tof), 12'h0);
    pulse_sleep;
    ext_n = 0;
    wait_wake;
    chk(12'(pcl), 12'h1);
    ext_n = 1;
    end_of_test;
  end
endmodule
